/* dtt_pkg.sv */
// package of constants for the dual and teaching timer block
package dtt_pkg;
   // ==========================================================
   // clock and timebase
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned TICK_1MS_US     = 1000;
   localparam int unsigned CYC_PER_1MS     = (CLK_HZ / 1000000) * TICK_1MS_US;
   localparam int unsigned MS_PER_10MS     = 10;
   localparam int unsigned MS_PER_100MS    = 100;
   localparam int unsigned MS_PER_1S       = 1000;
   // ==========================================================
   // widths and work area
   localparam int unsigned DUR_W           = 16;
   localparam int unsigned NUM_DUAL        = 4;
   localparam int unsigned DUAL_WORK_WORDS = 2;
   localparam int unsigned TEACH_WORDS     = 3;
   localparam logic [15:0] WORD_RESET      = 16'h0000;
   // ==========================================================
   // resolution index of each dual timer
   localparam int unsigned RES_1S          = 0;
   localparam int unsigned RES_100MS       = 1;
   localparam int unsigned RES_10MS        = 2;
   localparam int unsigned RES_1MS         = 3;
   typedef enum logic [0:0] {DTT_ON, DTT_OFF} dtt_phase_t;
endpackage : dtt_pkg

/* dtt_tick_div.sv */
// divider making a one-cycle tick every DIV enable pulses
`timescale 1ns/1ps
`default_nettype none
module dtt_tick_div
   import dtt_pkg::*;
#(
   parameter int unsigned DIV = 10
) (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic en_in,
   output var  logic tick
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic        next_tick;

   always_comb begin
      next_cnt  = cnt;
      next_tick = 1'b0;
      if (en_in) begin
         if (cnt == 16'(DIV - 1)) begin
            next_cnt  = 16'h0000;
            next_tick = 1'b1;
         end else begin
            next_cnt = cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt  <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule : dtt_tick_div
`default_nettype wire

/* dtt_dual.sv */
// one dual timer: on/off pulse train while started
`timescale 1ns/1ps
`default_nettype none
module dtt_dual
   import dtt_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             run,
   input  wire logic             tick,
   input  wire logic [DUR_W-1:0] on_duration,
   input  wire logic [DUR_W-1:0] off_duration,
   output var  logic             timer_out,
   output var  logic [DUR_W-1:0] work_elapsed,
   output var  logic             work_phase
);
   dtt_phase_t       phase;
   dtt_phase_t       next_phase;
   logic [DUR_W-1:0] elapsed;
   logic [DUR_W-1:0] next_elapsed;
   logic [DUR_W-1:0] limit;
   logic             next_out;

   always_comb begin
      next_phase   = phase;
      next_elapsed = elapsed;
      limit        = (phase == DTT_ON) ? on_duration : off_duration;
      if (!run) begin
         next_phase   = DTT_ON; // R14
         next_elapsed = '0;
      end else if (limit == '0) begin
         next_phase   = (phase == DTT_ON) ? DTT_OFF : DTT_ON; // R15
         next_elapsed = '0;
      end else if (tick) begin
         if (elapsed + 16'h0001 >= limit) begin
            next_phase   = (phase == DTT_ON) ? DTT_OFF : DTT_ON; // R1
            next_elapsed = '0;
         end else begin
            next_elapsed = elapsed + 16'h0001;
         end
      end
      // zero-length phases are skipped so output follows the nonzero one
      if (!run) begin
         next_out = 1'b0;
      end else if (next_phase == DTT_ON) begin
         next_out = (on_duration != '0) || (off_duration == '0 && on_duration != '0);
      end else begin
         next_out = (off_duration == '0) && (on_duration != '0);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         phase     <= DTT_ON;
         elapsed   <= '0;
         timer_out <= 1'b0;
      end else begin
         phase     <= next_phase;
         elapsed   <= next_elapsed;
         timer_out <= next_out;
      end
   end

   assign work_elapsed = elapsed; // R4
   assign work_phase   = (phase == DTT_OFF);

   a_off_when_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !run |=> !timer_out) else $error("dual output high while stopped"); // R14
endmodule : dtt_dual
`default_nettype wire

/* dtt_top.sv */
// top of the dual and teaching timer block
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: while started, output high for on count, low for off count, repeating.
// R2: 10 ms timer counts 10 ms ticks, range 0 to 655.35 s.
// R3: 1 ms timer counts 1 ms ticks, range 0 to 65.535 s.
// R4: each dual timer has two private work words nobody else writes.
// R5: dual timer invoked from interrupt is refused and raises error flag.
// R6: teach timer counts input high time in 100 ms units into result.
// R7: teach result spans 0 to 6553.5 s as 16-bit count.
// R8: teach input rise clears result then starts accumulating.
// R9: teach input fall stops counting and holds result until next rise.
// R10: teach timer uses result word plus two private work words; the code keeps one, teach_work_sub.
// R11: teach timer invoked from interrupt is rejected and raises error flag.
// R12: 1 s timer counts 1 s ticks, range 0 to 65535 s.
// R13: 100 ms timer counts 100 ms ticks, range 0 to 6553.5 s.
// R14: start low drives output low and restarts with on phase.
// R15: zero phase duration is skipped immediately.
module dtt_top
   import dtt_pkg::*;
#(
   parameter int unsigned CYC_1MS = CYC_PER_1MS
) (
   input  wire logic                      mclk,
   input  wire logic                      rstn,
   input  wire logic [NUM_DUAL-1:0]       dual_start,
   input  wire logic [NUM_DUAL-1:0]       dual_in_irq,
   input  wire logic [NUM_DUAL*DUR_W-1:0] on_duration,
   input  wire logic [NUM_DUAL*DUR_W-1:0] off_duration,
   input  wire logic                      teach_start,
   input  wire logic                      teach_in_irq,
   input  wire logic                      error_clear,
   output var  logic [NUM_DUAL-1:0]       dual_out,
   output var  logic [DUR_W-1:0]          timer_output_or_result,
   output var  logic [DUR_W-1:0]          teach_work_sub,
   output var  logic                      teach_active,
   output var  logic                      program_exec_error_flag,
   output var  logic                      error_led
);
   // ==========================================================
   // start input synchronisers
   logic [NUM_DUAL-1:0] ds_ff1;
   logic [NUM_DUAL-1:0] ds_ff2;
   logic [NUM_DUAL-1:0] ds_ff3;
   logic [NUM_DUAL-1:0] ds_lvl;
   logic [NUM_DUAL-1:0] next_ds_lvl;
   logic                ts_ff1;
   logic                ts_ff2;
   logic                ts_ff3;
   logic                ts_lvl;
   logic                next_ts_lvl;

   always_comb begin
      next_ds_lvl = ds_lvl;
      next_ts_lvl = ts_lvl;
      for (int i = 0; i < NUM_DUAL; i++) begin
         if (ds_ff2[i] == ds_ff3[i]) begin
            next_ds_lvl[i] = ds_ff3[i];
         end
      end
      if (ts_ff2 == ts_ff3) begin
         next_ts_lvl = ts_ff3;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ds_ff1 <= '0;
         ds_ff2 <= '0;
         ds_ff3 <= '0;
         ds_lvl <= '0;
         ts_ff1 <= 1'b0;
         ts_ff2 <= 1'b0;
         ts_ff3 <= 1'b0;
         ts_lvl <= 1'b0;
      end else begin
         ds_ff1 <= dual_start;
         ds_ff2 <= ds_ff1;
         ds_ff3 <= ds_ff2;
         ds_lvl <= next_ds_lvl;
         ts_ff1 <= teach_start;
         ts_ff2 <= ts_ff1;
         ts_ff3 <= ts_ff2;
         ts_lvl <= next_ts_lvl;
      end
   end

   // ==========================================================
   // timebase: 1 ms, 10 ms, 100 ms, 1 s ticks
   logic [15:0] ms_cnt;
   logic [15:0] next_ms_cnt;
   logic        tick_1ms;
   logic        next_tick_1ms;
   logic        tick_10ms;
   logic        tick_100ms;
   logic        tick_1s;

   always_comb begin
      next_tick_1ms = 1'b0;
      if (ms_cnt == 16'(CYC_1MS - 1)) begin
         next_ms_cnt   = 16'h0000;
         next_tick_1ms = 1'b1;
      end else begin
         next_ms_cnt = ms_cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ms_cnt   <= 16'h0000;
         tick_1ms <= 1'b0;
      end else begin
         ms_cnt   <= next_ms_cnt;
         tick_1ms <= next_tick_1ms;
      end
   end

   dtt_tick_div #(.DIV(MS_PER_10MS)) u_div10 (
      .mclk  (mclk),
      .rstn  (rstn),
      .en_in (tick_1ms),
      .tick  (tick_10ms)
   );

   dtt_tick_div #(.DIV(MS_PER_100MS / MS_PER_10MS)) u_div100 (
      .mclk  (mclk),
      .rstn  (rstn),
      .en_in (tick_10ms),
      .tick  (tick_100ms)
   );

   dtt_tick_div #(.DIV(MS_PER_1S / MS_PER_100MS)) u_div1s (
      .mclk  (mclk),
      .rstn  (rstn),
      .en_in (tick_100ms),
      .tick  (tick_1s)
   );

   // ==========================================================
   // dual timers, one per resolution
   logic [NUM_DUAL-1:0] tick_sel;
   logic [NUM_DUAL-1:0] dual_run;
   logic [NUM_DUAL-1:0] dual_q;

   always_comb begin
      tick_sel            = '0;
      tick_sel[RES_1S]    = tick_1s;    // R12
      tick_sel[RES_100MS] = tick_100ms; // R13
      tick_sel[RES_10MS]  = tick_10ms;  // R2
      tick_sel[RES_1MS]   = tick_1ms;   // R3
      dual_run            = ds_lvl & ~dual_in_irq; // R5
   end

   for (genvar g = 0; g < NUM_DUAL; g++) begin : g_dual
      dtt_dual u_dual (
         .mclk         (mclk),
         .rstn         (rstn),
         .run          (dual_run[g]),
         .tick         (tick_sel[g]),
         .on_duration  (on_duration[g*DUR_W +: DUR_W]),
         .off_duration (off_duration[g*DUR_W +: DUR_W]),
         .timer_out    (dual_q[g]),
         .work_elapsed (),
         .work_phase   ()
      );
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dual_out <= '0;
      end else begin
         dual_out <= dual_q;
      end
   end

   // ==========================================================
   // teaching timer
   logic             teach_run;
   logic             teach_prev;
   logic [DUR_W-1:0] next_result;
   logic [DUR_W-1:0] next_sub;
   logic             next_active;

   always_comb begin
      teach_run   = ts_lvl & ~teach_in_irq; // R11
      next_result = timer_output_or_result; // R9
      next_sub    = teach_work_sub;
      next_active = teach_run;
      if (teach_run && !teach_prev) begin
         next_result = '0; // R8
         next_sub    = '0;
      end else if (teach_run && tick_100ms) begin
         if (timer_output_or_result != 16'hFFFF) begin
            next_result = timer_output_or_result + 16'h0001; // R6 R7
         end
         next_sub = teach_work_sub + 16'h0001; // R10
      end
      // falling start leaves the result untouched
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         teach_prev             <= 1'b0;
         timer_output_or_result <= WORD_RESET;
         teach_work_sub         <= WORD_RESET;
         teach_active           <= 1'b0;
      end else begin
         teach_prev             <= teach_run;
         timer_output_or_result <= next_result;
         teach_work_sub         <= next_sub;
         teach_active           <= next_active;
      end
   end

   // ==========================================================
   // execution error flag and indicator
   logic irq_err;
   logic next_err;

   always_comb begin
      irq_err  = (|(ds_lvl & dual_in_irq)) | (ts_lvl & teach_in_irq); // R5 R11
      next_err = program_exec_error_flag;
      if (irq_err) begin
         next_err = 1'b1;
      end else if (error_clear) begin
         next_err = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         program_exec_error_flag <= 1'b0;
         error_led               <= 1'b0;
      end else begin
         program_exec_error_flag <= next_err;
         error_led               <= next_err;
      end
   end

   // ==========================================================
   // checks
   sequence s_rise;
      teach_run && !teach_prev;
   endsequence

   sequence s_fall;
      !teach_run && teach_prev;
   endsequence

   // edges since the last 1 ms tick; all ones in reset so the release edge wraps it to zero
   logic [15:0] gap_cnt;
   logic [15:0] next_gap_cnt;

   always_comb begin
      next_gap_cnt = gap_cnt + 16'h0001;
      if (tick_1ms) begin
         next_gap_cnt = 16'h0000;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         gap_cnt <= 16'hFFFF;
      end else begin
         gap_cnt <= next_gap_cnt;
      end
   end

   a_teach_clear: assert property (@(posedge mclk) disable iff (!rstn)
      s_rise |=> timer_output_or_result == 16'h0000) else $error("result not cleared on rise"); // R8
   a_teach_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !teach_run && !teach_prev |=> $stable(timer_output_or_result)) else $error("result moved while idle"); // R9
   a_teach_step: assert property (@(posedge mclk) disable iff (!rstn)
      teach_run && teach_prev && tick_100ms && timer_output_or_result != 16'hFFFF
      |=> timer_output_or_result == $past(timer_output_or_result) + 16'h0001)
      else $error("teach count did not step"); // R6
   a_teach_sat: assert property (@(posedge mclk) disable iff (!rstn)
      timer_output_or_result == 16'hFFFF && !(teach_run && !teach_prev)
      |=> timer_output_or_result == 16'hFFFF) else $error("teach count wrapped"); // R7
   a_irq_error: assert property (@(posedge mclk) disable iff (!rstn)
      irq_err |=> program_exec_error_flag && error_led) else $error("interrupt use not flagged"); // R5
   a_irq_teach: assert property (@(posedge mclk) disable iff (!rstn)
      teach_in_irq && !teach_prev |=> timer_output_or_result == $past(timer_output_or_result))
      else $error("teach ran from interrupt"); // R11
   a_irq_dual: assert property (@(posedge mclk) disable iff (!rstn)
      dual_in_irq[0] |=> ##1 !dual_out[0]) else $error("dual ran from interrupt"); // R5
   a_idle_low: assert property (@(posedge mclk) disable iff (!rstn)
      !ds_lvl[1] |=> ##1 !dual_out[1]) else $error("dual output high while stopped"); // R14
   a_tick_1s: assert property (@(posedge mclk) disable iff (!rstn)
      tick_1s |-> $past(tick_100ms) && !tick_100ms) else $error("tick chain misaligned"); // R12
   a_teach_fall: assert property (@(posedge mclk) disable iff (!rstn)
      s_fall |=> $stable(timer_output_or_result)) else $error("result moved after fall"); // R9
   a_work_clear: assert property (@(posedge mclk) disable iff (!rstn)
      s_rise |=> teach_work_sub == 16'h0000) else $error("work word not cleared on rise"); // R10
   a_work_hold: assert property (@(posedge mclk) disable iff (!rstn)
      !teach_run |=> $stable(teach_work_sub)) else $error("work word moved while idle"); // R10
   a_teach_idle: assert property (@(posedge mclk) disable iff (!rstn)
      teach_in_irq |=> !teach_active) else $error("teach active from interrupt"); // R11
   a_err_sticky: assert property (@(posedge mclk) disable iff (!rstn)
      program_exec_error_flag && !error_clear |=> program_exec_error_flag) else $error("error flag dropped"); // R5
   a_err_clear: assert property (@(posedge mclk) disable iff (!rstn)
      !irq_err && error_clear |=> !program_exec_error_flag) else $error("error flag not cleared"); // R5
   a_led_flag: assert property (@(posedge mclk) disable iff (!rstn)
      error_led == program_exec_error_flag) else $error("indicator differs from flag"); // R5
   a_ms_gap: assert property (@(posedge mclk) disable iff (!rstn)
      tick_1ms == (gap_cnt == 16'(CYC_1MS - 1))) else $error("millisecond tick period wrong"); // R3
endmodule : dtt_top
`default_nettype wire

/* tb_dual_and_teaching_timer.sv */
// self-checking testbench for the dual and teaching timer block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_and_teaching_timer
   import dtt_pkg::*;
;
   // ==========================================================
   // signals and design
   localparam int unsigned CYC = 4;
   logic                      mclk;
   logic                      rstn;
   logic [NUM_DUAL-1:0]       dual_start;
   logic [NUM_DUAL-1:0]       dual_in_irq;
   logic [NUM_DUAL*DUR_W-1:0] on_duration;
   logic [NUM_DUAL*DUR_W-1:0] off_duration;
   logic                      teach_start;
   logic                      teach_in_irq;
   logic                      error_clear;
   logic [NUM_DUAL-1:0]       dual_out;
   logic [DUR_W-1:0]          result;
   logic [DUR_W-1:0]          work_sub;
   logic                      teach_active;
   logic                      err_flag;
   logic                      err_led;
   int                        errors;
   int                        checks_done;
   int unsigned               seed_v;
   int                        on_v [NUM_DUAL];
   int                        off_v [NUM_DUAL];
   int                        n;

   dtt_top #(.CYC_1MS(CYC)) i_dut (
      .mclk(mclk), .rstn(rstn), .dual_start(dual_start), .dual_in_irq(dual_in_irq),
      .on_duration(on_duration), .off_duration(off_duration), .teach_start(teach_start),
      .teach_in_irq(teach_in_irq), .error_clear(error_clear), .dual_out(dual_out),
      .timer_output_or_result(result), .teach_work_sub(work_sub), .teach_active(teach_active),
      .program_exec_error_flag(err_flag), .error_led(err_led)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic stop_test;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic cycles(input int k);
      repeat (k) @(posedge mclk);
   endtask : cycles

   function automatic int phase_cyc(input int g, input int d);
      int mul;
      mul = (g == RES_1S) ? MS_PER_1S : (g == RES_100MS) ? MS_PER_100MS : (g == RES_10MS) ? MS_PER_10MS : 1;
      return d * CYC * mul;
   endfunction : phase_cyc

   task automatic wait_out(input int g, input logic lvl, input int limit);
      int k;
      k = 0;
      while (dual_out[g] !== lvl) begin
         @(posedge mclk);
         k++;
         if (k > limit) begin
            check(16'h0, 16'h1, "wait timed out");
            stop_test();
         end
      end
   endtask : wait_out

   task automatic run_len(input int g, input logic lvl, input int limit, output int k);
      k = 0;
      while (dual_out[g] === lvl && k <= limit) begin
         @(posedge mclk);
         k++;
      end
   endtask : run_len

   // skips the first, possibly short, on phase
   task automatic measure(input int g);
      int hi;
      int lo;
      int lim;
      lim = 3 * phase_cyc(g, on_v[g] + off_v[g]) + 64;
      wait_out(g, 1'b1, lim);
      wait_out(g, 1'b0, lim);
      wait_out(g, 1'b1, lim);
      run_len(g, 1'b1, lim, hi);
      run_len(g, 1'b0, lim, lo);
      check(16'(hi), 16'(phase_cyc(g, on_v[g])), "on length");
      check(16'(lo), 16'(phase_cyc(g, off_v[g])), "off length");
   endtask : measure

   task automatic restart(input logic [15:0] on, input logic [15:0] off);
      dual_start[3]                  <= 1'b0;
      on_duration[3*DUR_W +: DUR_W]  <= on;
      off_duration[3*DUR_W +: DUR_W] <= off;
      cycles(10);
      dual_start[3] <= 1'b1;
      cycles(10);
   endtask : restart

   task automatic teach(input int m);
      logic [15:0] r;
      teach_start <= 1'b1;
      cycles(8);
      check({15'h0, (result <= 16'h0001)}, 16'h1, "result cleared");
      check({15'h0, teach_active}, 16'h1, "measuring");
      cycles(m * CYC * MS_PER_100MS - 8);
      teach_start <= 1'b0;
      cycles(10);
      r = result;
      check({15'h0, (r + 1 >= m) && (r <= m + 1)}, 16'h1, "measured value");
      check({15'h0, (work_sub + 1 >= m) && (work_sub <= m + 1)}, 16'h1, "work word count");
      cycles(1200);
      check(result, r, "result held");
      check({15'h0, teach_active}, 16'h0, "stopped");
   endtask : teach
   // ==========================================================
   // main sequence
   initial begin
      rstn         = 1'b0;
      dual_start   = '0;
      dual_in_irq  = '0;
      on_duration  = '0;
      off_duration = '0;
      teach_start  = 1'b0;
      teach_in_irq = 1'b0;
      error_clear  = 1'b0;
      errors       = 0;
      checks_done  = 0;
      seed_v       = $urandom(32'hE303);
      cycles(12);
      rstn <= 1'b1;
      cycles(2);
      check({9'h0, dual_out, teach_active, err_flag, err_led}, 16'h0, "reset outputs");
      check(result, WORD_RESET, "reset result");
      check(work_sub, WORD_RESET, "reset work word");
      on_v[0]  = 1;
      off_v[0] = 1;
      on_v[1]  = 2;
      off_v[1] = 1;
      on_v[2]  = 1 + $urandom % 3;
      off_v[2] = 1 + $urandom % 3;
      on_v[3]  = 1 + $urandom % 6;
      off_v[3] = 1 + $urandom % 6;
      for (int g = 0; g < NUM_DUAL; g++) begin
         on_duration[g*DUR_W +: DUR_W]  <= 16'(on_v[g]);
         off_duration[g*DUR_W +: DUR_W] <= 16'(off_v[g]);
      end
      dual_start <= 4'hF;
      measure(RES_1MS);
      measure(RES_10MS);
      measure(RES_100MS);
      measure(RES_1S);
      // stop holds low, restart begins with on
      restart(16'h0014, 16'h0014);
      check({15'h0, dual_out[3]}, 16'h1, "fresh on phase");
      dual_start[3] <= 1'b0;
      cycles(10);
      run_len(3, 1'b0, 200, n);
      check(16'(n), 16'h00C9, "low while stopped");
      // zero phase lengths
      restart(16'h0003, 16'h0000);
      run_len(3, 1'b1, 300, n);
      check(16'(n), 16'h012D, "off phase empty");
      restart(16'h0000, 16'h0003);
      run_len(3, 1'b0, 300, n);
      check(16'(n), 16'h012D, "on phase empty");
      // interrupt context refusal, set beats clear
      restart(16'h0014, 16'h0014);
      dual_in_irq[3] <= 1'b1;
      error_clear    <= 1'b1;
      cycles(10);
      check({13'h0, dual_out[3], err_flag, err_led}, 16'h3, "dual refused");
      dual_in_irq[3] <= 1'b0;
      cycles(4);
      check({14'h0, err_flag, err_led}, 16'h0, "error cleared");
      error_clear <= 1'b0;
      dual_start  <= '0;
      cycles(10);
      // teaching timer
      teach(5);
      teach(1 + $urandom % 3);
      n = result;
      teach_start  <= 1'b1;
      teach_in_irq <= 1'b1;
      cycles(10);
      check({14'h0, err_flag, err_led}, 16'h3, "teach refused");
      check(result, 16'(n), "result kept when refused");
      check({15'h0, teach_active}, 16'h0, "not measuring when refused");
      teach_start  <= 1'b0;
      teach_in_irq <= 1'b0;
      cycles(4);
      error_clear <= 1'b1;
      cycles(4);
      check({14'h0, err_flag, err_led}, 16'h0, "teach error cleared");
      error_clear <= 1'b0;
      stop_test();
   end
endmodule : tb_dual_and_teaching_timer
`default_nettype wire
